// [hw/pwm_pair_pkg.sv]
package pwm_pair_pkg;

	// ------------------------------------------------------------
	// channel layout
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_POWER = 8'h00;
	localparam logic [7:0] OFS_PRESCALE = 8'h04;
	localparam logic [7:0] OFS_OUT_VALUE = 8'h08;
	localparam logic [7:0] OFS_OUT_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_OUT_POLARITY = 8'h10;
	localparam logic [7:0] OFS_OUT_MODE = 8'h14;
	localparam logic [7:0] OFS_PORT_MODE = 8'h18;
	localparam logic [7:0] OFS_START = 8'h1C;
	localparam logic [7:0] OFS_STOP = 8'h20;
	localparam logic [7:0] OFS_RUN_STATUS = 8'h24;
	localparam logic [7:0] OFS_MODE_BASE = 8'h40;
	localparam logic [7:0] OFS_DATA_BASE = 8'h50;
	localparam logic [7:0] OFS_COUNT_BASE = 8'h60;
	localparam logic [7:0] OFS_ARRAY_MASK = 8'hF0;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int POWER_BIT = 0;
	localparam int PRESCALE_A_LSB = 0;
	localparam int PRESCALE_B_LSB = 4;
	localparam int PRESCALE_W = 4;
	localparam logic [3:0] PORT_MODE_RESET = 4'hF;
	localparam logic [15:0] IDLE_FULL = 16'hFFFF;
	localparam logic [15:0] IDLE_SPLIT = 16'h00FF;
	localparam logic [15:0] DATA_RESET = 16'hFFFF;

	// mode register: clock select on top, pair bit at 11
	typedef struct packed {
		logic clk_sel;
		logic [2:0] rsv_a;
		logic pair_bit;
		logic [10:0] rsv_b;
	} mode_t;

	typedef enum logic {
		CH_STOP = 1'b0,
		CH_RUN = 1'b1
	} ch_state_t;

endpackage

// [hw/timer_pair_pwm_output_setup.sv]
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - output enable 0: counting leaves pin, pin shows stored output value
// R2 - output enable 1: counting events drive the pin level
// R3 - output value bit 0 drives low, 1 drives high
// R4 - polarity 0 active-high pulse, 1 active-low pulse
// R5 - output mode 1: master event sets, slave count end clears
// R6 - output mode 0: master mode, polarity ignored, output toggles
// R7 - mode register clock select 1 picks second prescaled clock
// R8 - prescaler makes two shared clocks, each channel picks one
// R9 - power bit 0: no clock, register reads and writes blocked
// R10 - power bit 1: clock and writes enabled, channels stay stopped
// R11 - software loads period and duty data and modes before start
// R12 - software clears master output mode, polarity and enable first
// R13 - software sets slave mode, polarity, default level, then enable
// R14 - stopped channel value change stays off pin until port output
// R15 - port mode input keeps the pin high impedance
// R16 - only channels 0 and 2 master; higher channels up to 3 slave
// R17 - channel 2 mode has master select; channel 0 fixed at 0
// R18 - channels 1 and 3 mode carry split bit for 8-bit timing
// R19 - period is master data plus one count clocks
// R20 - pin active one count clock after master event, off at zero
// R21 - slave one-count: reload on trigger, down to zero, park all ones
// R22 - stop freezes counters and holds the pin level
module timer_pair_pwm_output_setup (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// avalon-mm slave
	input wire logic [pwm_pair_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [pwm_pair_pkg::DATA_W-1:0] avs_writedata_i,
	output logic [pwm_pair_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// pwm pins, output enable low while driving
	output logic [pwm_pair_pkg::NUM_CH-1:0] slave_pwm_pin_o,
	output logic [pwm_pair_pkg::NUM_CH-1:0] slave_pwm_pin_oe_n_o
);

	localparam int N = pwm_pair_pkg::NUM_CH;
	localparam int W = pwm_pair_pkg::CNT_W;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic div_tick(input logic [W-1:0] cnt,
		input logic [3:0] sel);
		logic [W-1:0] mask;
		mask = W'((32'h1 << sel) - 32'h1);
		return (cnt & mask) == mask;
	endfunction

	function automatic logic is_master(input int ch, input logic msel2);
		return (ch == 0) || (ch == 2 && msel2);
	endfunction

	function automatic int trig_src(input int ch, input logic msel2);
		return (ch == 3 && msel2) ? 2 : 0;
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic power_reg;
	logic [7:0] prescale_reg;
	logic [N-1:0] output_value_reg;
	logic [N-1:0] output_enable_reg;
	logic [N-1:0] output_polarity_reg;
	logic [N-1:0] output_mode_reg;
	logic [N-1:0] port_mode_reg;
	pwm_pair_pkg::mode_t mode_reg [N];
	logic [W-1:0] data_reg [N];
	logic [W-1:0] cnt_reg [N];
	pwm_pair_pkg::ch_state_t state_reg [N];
	logic [N-1:0] pend_reg;
	logic [W-1:0] pre_cnt_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;

	logic wr_en;
	logic rd_req;
	logic msel2;
	logic tick_a;
	logic tick_b;
	logic [N-1:0] tick;
	logic [N-1:0] master;
	logic [N-1:0] start_w;
	logic [N-1:0] stop_w;
	logic [N-1:0] mev;
	logic [N-1:0] trig;
	logic [N-1:0] sload;
	logic [N-1:0] send;
	logic [W-1:0] idle [N];
	logic [W-1:0] reload [N];
	logic [31:0] rdata_next;

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign slave_pwm_pin_o = output_value_reg; // R3
	assign slave_pwm_pin_oe_n_o = port_mode_reg; // R15 R14

	// ------------------------------------------------------------
	// avalon handshake: answer one cycle after the request
	// ------------------------------------------------------------
	assign wr_en = avs_write_i && !wait_reg;
	assign rd_req = avs_read_i && wait_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= !((avs_read_i || avs_write_i) && wait_reg);
		end
	end

	always_comb begin
		rdata_next = 32'h0;
		if (avs_address_i == pwm_pair_pkg::OFS_POWER) begin
			rdata_next[pwm_pair_pkg::POWER_BIT] = power_reg;
		end else if (power_reg) begin // R9
			unique case (avs_address_i)
				pwm_pair_pkg::OFS_PRESCALE: rdata_next[7:0] = prescale_reg;
				pwm_pair_pkg::OFS_OUT_VALUE: rdata_next[N-1:0] = output_value_reg;
				pwm_pair_pkg::OFS_OUT_ENABLE:
					rdata_next[N-1:0] = output_enable_reg;
				pwm_pair_pkg::OFS_OUT_POLARITY:
					rdata_next[N-1:0] = output_polarity_reg;
				pwm_pair_pkg::OFS_OUT_MODE: rdata_next[N-1:0] = output_mode_reg;
				pwm_pair_pkg::OFS_PORT_MODE: rdata_next[N-1:0] = port_mode_reg;
				pwm_pair_pkg::OFS_RUN_STATUS: begin
					for (int i = 0; i < N; i++) begin
						rdata_next[i] = (state_reg[i] == pwm_pair_pkg::CH_RUN);
					end
				end
				default: begin
					for (int i = 0; i < N; i++) begin
						if (avs_address_i == pwm_pair_pkg::OFS_MODE_BASE + 8'(4*i)) begin
							rdata_next[W-1:0] = mode_reg[i];
						end
						if (avs_address_i == pwm_pair_pkg::OFS_DATA_BASE + 8'(4*i)) begin
							rdata_next[W-1:0] = data_reg[i];
						end
						if (avs_address_i == pwm_pair_pkg::OFS_COUNT_BASE + 8'(4*i)) begin
							rdata_next[W-1:0] = cnt_reg[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 32'h0;
		end else if (rd_req) begin
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// configuration writes; power off resets the whole unit
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			power_reg <= 1'b0;
		end else if (wr_en && avs_address_i == pwm_pair_pkg::OFS_POWER) begin
			power_reg <= avs_writedata_i[pwm_pair_pkg::POWER_BIT]; // R10
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prescale_reg <= 8'h00;
			output_enable_reg <= 4'h0;
			output_polarity_reg <= 4'h0;
			output_mode_reg <= 4'h0;
			port_mode_reg <= pwm_pair_pkg::PORT_MODE_RESET;
			for (int i = 0; i < N; i++) begin
				mode_reg[i] <= '0;
				data_reg[i] <= pwm_pair_pkg::DATA_RESET;
			end
		end else if (!power_reg) begin // R9
			prescale_reg <= 8'h00;
			output_enable_reg <= 4'h0;
			output_polarity_reg <= 4'h0;
			output_mode_reg <= 4'h0;
			port_mode_reg <= pwm_pair_pkg::PORT_MODE_RESET;
			for (int i = 0; i < N; i++) begin
				mode_reg[i] <= '0;
				data_reg[i] <= pwm_pair_pkg::DATA_RESET;
			end
		end else if (wr_en) begin
			unique case (avs_address_i)
				pwm_pair_pkg::OFS_PRESCALE: prescale_reg <= avs_writedata_i[7:0]; // R8
				pwm_pair_pkg::OFS_OUT_ENABLE:
					output_enable_reg <= avs_writedata_i[N-1:0];
				pwm_pair_pkg::OFS_OUT_POLARITY:
					output_polarity_reg <= avs_writedata_i[N-1:0];
				pwm_pair_pkg::OFS_OUT_MODE: output_mode_reg <= avs_writedata_i[N-1:0];
				pwm_pair_pkg::OFS_PORT_MODE: port_mode_reg <= avs_writedata_i[N-1:0];
				default: begin
					for (int i = 0; i < N; i++) begin
						if (avs_address_i == pwm_pair_pkg::OFS_MODE_BASE + 8'(4*i)) begin
							mode_reg[i] <= avs_writedata_i[W-1:0];
							if (i == 0) begin
								mode_reg[i].pair_bit <= 1'b0; // R17
							end
						end
						if (avs_address_i == pwm_pair_pkg::OFS_DATA_BASE + 8'(4*i)) begin
							data_reg[i] <= avs_writedata_i[W-1:0];
						end
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// prescaler and channel roles
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_cnt_reg <= '0;
		end else if (!power_reg) begin
			pre_cnt_reg <= '0;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + W'(1);
		end
	end

	assign tick_a = power_reg && div_tick(pre_cnt_reg,
		prescale_reg[pwm_pair_pkg::PRESCALE_A_LSB +: pwm_pair_pkg::PRESCALE_W]);
	assign tick_b = power_reg && div_tick(pre_cnt_reg,
		prescale_reg[pwm_pair_pkg::PRESCALE_B_LSB +: pwm_pair_pkg::PRESCALE_W]);
	assign msel2 = mode_reg[2].pair_bit; // R17

	always_comb begin
		for (int i = 0; i < N; i++) begin
			tick[i] = mode_reg[i].clk_sel ? tick_b : tick_a; // R7 R8
			master[i] = is_master(i, msel2); // R16
			// split bit narrows channels 1 and 3 to 8 bits
			idle[i] = (i % 2 == 1 && mode_reg[i].pair_bit) ?
				pwm_pair_pkg::IDLE_SPLIT : pwm_pair_pkg::IDLE_FULL; // R18
			reload[i] = data_reg[i] & idle[i];
			start_w[i] = wr_en && power_reg && avs_writedata_i[i] &&
				avs_address_i == pwm_pair_pkg::OFS_START;
			stop_w[i] = wr_en && power_reg && avs_writedata_i[i] &&
				avs_address_i == pwm_pair_pkg::OFS_STOP;
		end
		for (int i = 0; i < N; i++) begin
			mev[i] = master[i] && !stop_w[i] && (start_w[i] ||
				(state_reg[i] == pwm_pair_pkg::CH_RUN && tick[i] &&
				cnt_reg[i] == '0));
		end
		for (int i = 0; i < N; i++) begin
			trig[i] = !master[i] && state_reg[i] == pwm_pair_pkg::CH_RUN &&
				mev[trig_src(i, msel2)];
			sload[i] = !master[i] && !stop_w[i] &&
				state_reg[i] == pwm_pair_pkg::CH_RUN && tick[i] && pend_reg[i];
			send[i] = !master[i] && !stop_w[i] &&
				state_reg[i] == pwm_pair_pkg::CH_RUN && tick[i] &&
				!pend_reg[i] && cnt_reg[i] == W'(1);
		end
	end

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < N; i++) begin
				state_reg[i] <= pwm_pair_pkg::CH_STOP;
				cnt_reg[i] <= pwm_pair_pkg::IDLE_FULL;
			end
		end else if (!power_reg) begin // R10
			for (int i = 0; i < N; i++) begin
				state_reg[i] <= pwm_pair_pkg::CH_STOP;
				cnt_reg[i] <= pwm_pair_pkg::IDLE_FULL;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (stop_w[i]) begin
					state_reg[i] <= pwm_pair_pkg::CH_STOP; // R22
				end else if (start_w[i]) begin
					state_reg[i] <= pwm_pair_pkg::CH_RUN;
					cnt_reg[i] <= master[i] ? data_reg[i] : idle[i];
				end else if (state_reg[i] == pwm_pair_pkg::CH_RUN && tick[i]) begin
					if (master[i]) begin
						cnt_reg[i] <= (cnt_reg[i] == '0) ? data_reg[i] :
							cnt_reg[i] - W'(1); // R19
					end else if (pend_reg[i]) begin
						cnt_reg[i] <= reload[i]; // R21
					end else if (cnt_reg[i] == '0) begin
						cnt_reg[i] <= idle[i]; // R21
					end else if (cnt_reg[i] != idle[i]) begin
						cnt_reg[i] <= cnt_reg[i] - W'(1);
					end
				end
			end
		end
	end

	// trigger waits for the slave's own count clock; new trigger wins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_reg <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (!power_reg || stop_w[i] ||
					state_reg[i] != pwm_pair_pkg::CH_RUN) begin
					pend_reg[i] <= 1'b0;
				end else if (trig[i]) begin
					pend_reg[i] <= 1'b1; // R20
				end else if (tick[i]) begin
					pend_reg[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			output_value_reg <= 4'h0;
		end else if (!power_reg) begin
			output_value_reg <= 4'h0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (!output_enable_reg[i]) begin
					if (wr_en && avs_address_i == pwm_pair_pkg::OFS_OUT_VALUE) begin
						output_value_reg[i] <= avs_writedata_i[i]; // R1 R3
					end
				end else if (!output_mode_reg[i]) begin
					if (mev[i]) begin
						output_value_reg[i] <= !output_value_reg[i]; // R6 R2
					end
				end else if (sload[i]) begin
					// zero duty never goes active
					output_value_reg[i] <= (reload[i] != '0) ?
						!output_polarity_reg[i] : output_polarity_reg[i]; // R5 R4
				end else if (send[i]) begin
					output_value_reg[i] <= output_polarity_reg[i]; // R20
				end
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_disabled_static;
		@(posedge clk_i) disable iff (!arst_n_i)
		power_reg && !output_enable_reg[1] &&
			!(wr_en && avs_address_i == pwm_pair_pkg::OFS_OUT_VALUE)
			|=> output_value_reg[1] == $past(output_value_reg[1]);
	endproperty
	a_disabled_static: assert property (p_disabled_static) // R1
		else $error("disabled output changed without a write");

	property p_slave_active;
		@(posedge clk_i) disable iff (!arst_n_i)
		sload[1] && output_enable_reg[1] && output_mode_reg[1] &&
			reload[1] != '0
			|=> output_value_reg[1] != output_polarity_reg[1];
	endproperty
	a_slave_active: assert property (p_slave_active) // R5
		else $error("slave output not active after reload");

	property p_slave_inactive;
		@(posedge clk_i) disable iff (!arst_n_i)
		send[1] && output_enable_reg[1] && output_mode_reg[1]
			|=> output_value_reg[1] == output_polarity_reg[1] &&
			cnt_reg[1] == '0;
	endproperty
	a_slave_inactive: assert property (p_slave_inactive) // R20
		else $error("slave output not inactive at zero");

	property p_master_toggle;
		@(posedge clk_i) disable iff (!arst_n_i)
		mev[0] && output_enable_reg[0] && !output_mode_reg[0]
			|=> output_value_reg[0] != $past(output_value_reg[0]);
	endproperty
	a_master_toggle: assert property (p_master_toggle) // R6
		else $error("master output did not toggle on event");

	property p_power_read;
		@(posedge clk_i) disable iff (!arst_n_i)
		rd_req && !power_reg && avs_address_i != pwm_pair_pkg::OFS_POWER
			|=> !avs_waitrequest_o && avs_readdata_o == 32'h0;
	endproperty
	a_power_read: assert property (p_power_read) // R9
		else $error("read while unit powered off not blocked");

	property p_power_stop;
		@(posedge clk_i) disable iff (!arst_n_i)
		!power_reg ##1 power_reg |-> state_reg[0] == pwm_pair_pkg::CH_STOP &&
			state_reg[1] == pwm_pair_pkg::CH_STOP;
	endproperty
	a_power_stop: assert property (p_power_stop) // R10
		else $error("channel running right after power on");

	property p_one_count;
		@(posedge clk_i) disable iff (!arst_n_i)
		!master[1] && state_reg[1] == pwm_pair_pkg::CH_RUN && tick[1] &&
			!pend_reg[1] && cnt_reg[1] == '0 && !stop_w[1]
			|=> cnt_reg[1] == idle[1];
	endproperty
	a_one_count: assert property (p_one_count) // R21
		else $error("slave did not park at idle value");

	property p_stop_freeze;
		@(posedge clk_i) disable iff (!arst_n_i)
		stop_w[1] && power_reg |=> cnt_reg[1] == $past(cnt_reg[1]) &&
			output_value_reg[1] == $past(output_value_reg[1]) ##1
			state_reg[1] == pwm_pair_pkg::CH_STOP;
	endproperty
	a_stop_freeze: assert property (p_stop_freeze) // R22
		else $error("stop did not freeze counter and pin");

	property p_master_reload;
		@(posedge clk_i) disable iff (!arst_n_i)
		mev[0] |=> cnt_reg[0] == $past(data_reg[0]);
	endproperty
	a_master_reload: assert property (p_master_reload) // R19
		else $error("master did not reload period data");

endmodule // timer_pair_pwm_output_setup

`default_nettype wire

// [sim/pwm_load_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// pin side
	input wire logic [3:0] pin_i,
	input wire logic [3:0] pin_oe_n_i,
	// seen level and channel 1 pulse timing
	output logic [3:0] level_o,
	output logic [15:0] period_o,
	output logic [15:0] high_o
);
	logic [3:0] last_reg;
	logic prev_reg;
	logic [15:0] since_rise_reg;
	logic [15:0] high_cnt_reg;

	// --------------------------------------------------------------
	// line level
	// --------------------------------------------------------------
	// no pull on the load: a released line wanders, never holds value
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			level_o[k] = pin_oe_n_i[k] ? ~last_reg[k] : pin_i[k];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_reg <= 4'h0;
		end else begin
			last_reg <= level_o;
		end
	end

	// --------------------------------------------------------------
	// pulse timing, measured in system clock cycles
	// --------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_reg <= 1'b0;
			since_rise_reg <= 16'h0000;
			high_cnt_reg <= 16'h0000;
			period_o <= 16'h0000;
			high_o <= 16'h0000;
		end else begin
			prev_reg <= level_o[1];
			if (level_o[1] && !prev_reg) begin
				period_o <= since_rise_reg;
				since_rise_reg <= 16'h0001;
				high_cnt_reg <= 16'h0001;
			end else begin
				since_rise_reg <= since_rise_reg + 16'h0001;
				if (level_o[1]) begin
					high_cnt_reg <= high_cnt_reg + 16'h0001;
				end
			end
			if (!level_o[1] && prev_reg) begin
				high_o <= high_cnt_reg;
			end
		end
	end
endmodule // pwm_load_model

`default_nettype wire

// [sim/timer_pair_pwm_output_setup_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin \
	fail_count++; $display("MISMATCH %0t %s", $time, msg); end end

module timer_pair_pwm_output_setup_tb_top;
	// --------------------------------------------------------------
	// signals
	// --------------------------------------------------------------
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] address = 8'h00;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic waitreq;
	logic [3:0] pin;
	logic [3:0] oe_n;
	logic [3:0] level;
	logic [15:0] period;
	logic [15:0] high;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [15:0] lfsr = 16'h0012;

	always #50 clk_i = ~clk_i;

	timer_pair_pwm_output_setup i_timer_pair_pwm_output_setup (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.avs_address_i(address),
		.avs_read_i(rd_req),
		.avs_write_i(wr_req),
		.avs_writedata_i(wdata),
		.avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq),
		.slave_pwm_pin_o(pin),
		.slave_pwm_pin_oe_n_o(oe_n)
	);

	pwm_load_model i_pwm_load_model (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(pin),
		.pin_oe_n_i(oe_n),
		.level_o(level),
		.period_o(period),
		.high_o(high)
	);

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// request held until waitrequest is seen low at a rising edge;
	// data taken and request dropped at that same edge
	task automatic bus_xfer(input logic we, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		address <= a;
		wr_req <= we;
		rd_req <= ~we;
		wdata <= d;
		@(posedge clk_i);
		while (waitreq !== 1'b0) begin
			@(posedge clk_i);
		end
		q = rdata;
		wr_req <= 1'b0;
		rd_req <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus_xfer(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
			input string msg);
		logic [31:0] q;
		bus_xfer(1'b0, a, 32'h00000000, q);
		`CHK(q, e, msg)
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] exp_period(input logic [15:0] d,
			input logic [15:0] k);
		return (d + 16'h0001) * k;
	endfunction

	function automatic logic [15:0] exp_high(input logic [15:0] d,
			input logic [15:0] s, input logic pol, input logic [15:0] k);
		return pol ? (d + 16'h0001 - s) * k : s * k;
	endfunction

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin : main
		logic [15:0] d;
		logic [15:0] s;
		logic [15:0] k;
		logic pol;
		logic [3:0] held;
		logic [31:0] cnt;
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd_chk(pwm_pair_pkg::OFS_POWER, 32'h00000000, "power reset");
		wr(pwm_pair_pkg::OFS_OUT_VALUE, 32'h00000005);
		rd_chk(pwm_pair_pkg::OFS_PORT_MODE, 32'h00000000, "read off");
		wr(pwm_pair_pkg::OFS_POWER, 32'h00000001);
		rd_chk(pwm_pair_pkg::OFS_OUT_VALUE, 32'h00000000, "write off");
		rd_chk(pwm_pair_pkg::OFS_PORT_MODE,
			32'(pwm_pair_pkg::PORT_MODE_RESET), "port reset");
		rd_chk(pwm_pair_pkg::OFS_DATA_BASE,
			32'(pwm_pair_pkg::DATA_RESET), "data reset");
		rd_chk(pwm_pair_pkg::OFS_RUN_STATUS, 32'h00000000, "stopped");
		rd_chk(8'hFC, 32'h00000000, "unmapped");
		for (int n = 0; n < 4; n++) begin
			wr(pwm_pair_pkg::OFS_MODE_BASE + 8'(4 * n), 32'h00008800);
			rd_chk(pwm_pair_pkg::OFS_MODE_BASE + 8'(4 * n),
				(n == 0) ? 32'h00008000 : 32'h00008800, "pair bit");
		end
		// static level while the port is still an input
		wr(pwm_pair_pkg::OFS_OUT_ENABLE, 32'h00000000);
		wr(pwm_pair_pkg::OFS_OUT_VALUE, 32'h00000009);
		repeat (2) @(negedge clk_i);
		`CHK(oe_n, 4'hF, "pin not hi-z")
		wr(pwm_pair_pkg::OFS_PORT_MODE, 32'h00000000);
		repeat (2) @(negedge clk_i);
		`CHK(level, 4'h9, "static level")
		wr(pwm_pair_pkg::OFS_PRESCALE, 32'h00000010);
		for (int i = 0; i < 4; i++) begin
			pol = i[0];
			k = i[1] ? 16'h0002 : 16'h0001;
			lfsr = lfsr_next(lfsr);
			d = 16'h0003 + {11'h000, lfsr[4:0]};
			lfsr = lfsr_next(lfsr);
			s = (i == 3) ? d : 16'h0001 + lfsr % d;
			wr(pwm_pair_pkg::OFS_OUT_MODE, 32'h00000002);
			wr(pwm_pair_pkg::OFS_OUT_POLARITY, {30'h0, pol, 1'b0});
			wr(pwm_pair_pkg::OFS_OUT_ENABLE, 32'h00000000);
			wr(pwm_pair_pkg::OFS_OUT_VALUE, {28'h0, 2'h2, pol, 1'b0});
			wr(pwm_pair_pkg::OFS_OUT_ENABLE, 32'h00000002);
			wr(pwm_pair_pkg::OFS_MODE_BASE, {16'h0, i[1], 15'h0});
			wr(pwm_pair_pkg::OFS_MODE_BASE + 8'h04, {16'h0, i[1], 15'h0});
			wr(pwm_pair_pkg::OFS_DATA_BASE, {16'h0, d});
			wr(pwm_pair_pkg::OFS_DATA_BASE + 8'h04, {16'h0, s});
			wr(pwm_pair_pkg::OFS_START, 32'h00000003);
			repeat (3 * exp_period(d, k) + 20) @(negedge clk_i);
			`CHK(period, exp_period(d, k), "pwm period")
			`CHK(high, exp_high(d, s, pol, k), "pwm duty")
			`CHK(level[3], 1'b1, "idle pin moved")
			wr(pwm_pair_pkg::OFS_STOP, 32'h00000003);
			repeat (2) @(negedge clk_i);
			held = level;
			bus_xfer(1'b0, pwm_pair_pkg::OFS_COUNT_BASE + 8'h04, 32'h0, cnt);
			repeat (2 * exp_period(d, k)) @(negedge clk_i);
			`CHK(level, held, "pin moved after stop")
			rd_chk(pwm_pair_pkg::OFS_COUNT_BASE + 8'h04, cnt, "count moved");
		end
		// power cycle wipes the unit
		wr(pwm_pair_pkg::OFS_POWER, 32'h00000000);
		rd_chk(pwm_pair_pkg::OFS_OUT_ENABLE, 32'h00000000, "read off");
		wr(pwm_pair_pkg::OFS_POWER, 32'h00000001);
		rd_chk(pwm_pair_pkg::OFS_DATA_BASE,
			32'(pwm_pair_pkg::DATA_RESET), "not cleared");
		stop_test();
	end
endmodule // timer_pair_pwm_output_setup_tb_top

`default_nettype wire
